// *** verilog/gpp_pkg.sv ***
// Package for the eight-bit general-purpose port: offsets, reset values, keys and identity bytes
package gpp_pkg;

  localparam int GPP_PINS = 8;
  localparam int GPP_AW = 12;
  localparam int GPP_DW = 32;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [11:0] GPP_OFS_DIR = 12'h400;
  localparam logic [11:0] GPP_OFS_SENSE = 12'h404;
  localparam logic [11:0] GPP_OFS_BOTH = 12'h408;
  localparam logic [11:0] GPP_OFS_POL = 12'h40c;
  localparam logic [11:0] GPP_OFS_MASK = 12'h410;
  localparam logic [11:0] GPP_OFS_RAW = 12'h414;
  localparam logic [11:0] GPP_OFS_MIS = 12'h418;
  localparam logic [11:0] GPP_OFS_CLR = 12'h41c;
  localparam logic [11:0] GPP_OFS_AFSEL = 12'h420;
  localparam logic [11:0] GPP_OFS_DR2 = 12'h500;
  localparam logic [11:0] GPP_OFS_DR4 = 12'h504;
  localparam logic [11:0] GPP_OFS_DR8 = 12'h508;
  localparam logic [11:0] GPP_OFS_ODR = 12'h50c;
  localparam logic [11:0] GPP_OFS_PUR = 12'h510;
  localparam logic [11:0] GPP_OFS_PDR = 12'h514;
  localparam logic [11:0] GPP_OFS_SLR = 12'h518;
  localparam logic [11:0] GPP_OFS_DEN = 12'h51c;
  localparam logic [11:0] GPP_OFS_LOCK = 12'h520;
  localparam logic [11:0] GPP_OFS_COMMIT = 12'h524;

  // Pin value window spans 0x000-0x3fc; address bits [9:2] are the bit mask
  localparam logic [1:0] GPP_DATA_PAGE = 2'h0;
  localparam int GPP_DATA_MSB = 9;
  localparam int GPP_DATA_LSB = 2;
  // Identity block spans 0xfc0-0xffc, byte picked by address bits [5:2]
  localparam logic [5:0] GPP_ID_PAGE = 6'h3f;
  // Identity bytes are arbitrary neutral values; first four slots unmapped
  localparam logic [127:0] GPP_ID_TABLE = 128'h5a_3c_a5_c3_01_02_03_04_10_20_30_40_00_00_00_00;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and keys
  localparam logic [7:0] GPP_DR2_RST = 8'hff;
  localparam logic [31:0] GPP_UNLOCK_KEY = 32'h1234_abcd;
  localparam logic [31:0] GPP_LOCK_READ = 32'h0000_0001;

endpackage

// *** verilog/gpp_port.sv ***
// Eight-pin general-purpose port with pin interrupts, commit protection and pad control
//
// Notes on behaviour
// - One interrupt line for all unmasked pending pins
// - Edge pending stays set until software clears
// - Per-bit sense and both-edges selects
// - Polarity picks low/falling or high/rising
// - Mask bit gates forwarding to interrupt line
// - Raw status ignores the mask
// - Masked status equals raw AND mask
// - Clear register: one clears, zero ignored
// - Trigger pin pulses converter trigger when unmasked
// - Alternate select hands pin to peripheral
// - Protected alternate bits need unlock plus commit
// - Drive, open-drain, pulls, slew, enable per pin
// - Non-debug pins reset to tristate
// - Digital use needs digital enable set
// - Read-only identity registers fixed at reset
// - Direction zero input, one output
module gpp_port
  import gpp_pkg::*;
#(
  parameter logic [7:0] DEBUG_PIN_MASK = 8'h00,
  parameter bit HAS_TRIGGER = 1'b0,
  parameter int TRIGGER_PIN = 4
)(
  input wire logic clk,
  input wire logic srst,
  input wire logic [GPP_AW-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [GPP_DW-1:0] writedata,
  output logic [GPP_DW-1:0] readdata,
  output logic waitrequest,
  input wire logic [GPP_PINS-1:0] pad_in,
  output logic [GPP_PINS-1:0] pad_out,
  output logic [GPP_PINS-1:0] pad_oe,
  input wire logic [GPP_PINS-1:0] alt_out,
  input wire logic [GPP_PINS-1:0] alt_oe,
  output logic [GPP_PINS-1:0] alt_in,
  output logic [GPP_PINS-1:0] drive_2ma_select,
  output logic [GPP_PINS-1:0] drive_4ma_select,
  output logic [GPP_PINS-1:0] drive_8ma_select,
  output logic [GPP_PINS-1:0] slew_rate_select,
  output logic [GPP_PINS-1:0] pull_up_select,
  output logic [GPP_PINS-1:0] pull_down_select,
  output logic [GPP_PINS-1:0] digital_enable,
  output logic irq_out,
  output logic converter_trigger
);

  typedef struct packed {
    logic [GPP_PINS-1:0] sync1;
    logic [GPP_PINS-1:0] sync2;
    logic [GPP_PINS-1:0] sync3;
    logic [GPP_PINS-1:0] pin_value_reg;
    logic [GPP_PINS-1:0] direction_select;
    logic [GPP_PINS-1:0] irq_sense_select;
    logic [GPP_PINS-1:0] irq_both_edge_select;
    logic [GPP_PINS-1:0] irq_polarity_select;
    logic [GPP_PINS-1:0] irq_mask;
    logic [GPP_PINS-1:0] edge_pend;
    logic [GPP_PINS-1:0] mis_prev;
    logic [GPP_PINS-1:0] alt_function_select;
    logic [GPP_PINS-1:0] drive_2ma;
    logic [GPP_PINS-1:0] drive_4ma;
    logic [GPP_PINS-1:0] drive_8ma;
    logic [GPP_PINS-1:0] open_drain_select;
    logic [GPP_PINS-1:0] pull_up;
    logic [GPP_PINS-1:0] pull_down;
    logic [GPP_PINS-1:0] slew;
    logic [GPP_PINS-1:0] dig_en;
    logic [GPP_PINS-1:0] commit_allow;
    logic locked;
    logic ack;
    logic trig;
    logic [GPP_DW-1:0] rdata;
  } gpp_state_t;

  localparam logic [GPP_PINS-1:0] TRIG_SEL = HAS_TRIGGER ? GPP_PINS'(1 << TRIGGER_PIN) : '0;

  // Debug pins come up in their peripheral role; all others tristate
  localparam gpp_state_t ST_RST = '{
    alt_function_select: DEBUG_PIN_MASK,
    pull_up: DEBUG_PIN_MASK,
    dig_en: DEBUG_PIN_MASK,
    commit_allow: ~DEBUG_PIN_MASK,
    drive_2ma: GPP_DR2_RST,
    locked: 1'b1,
    default: '0
  };

  gpp_state_t st_ff;
  gpp_state_t nxt_st;

  logic [GPP_PINS-1:0] pin_in;
  logic [GPP_PINS-1:0] pin_prev;
  logic [GPP_PINS-1:0] rise;
  logic [GPP_PINS-1:0] fall;
  logic [GPP_PINS-1:0] edge_evt;
  logic [GPP_PINS-1:0] level_hit;
  logic [GPP_PINS-1:0] raw;
  logic [GPP_PINS-1:0] mis;
  logic [GPP_PINS-1:0] clr_bits;
  logic [GPP_PINS-1:0] afsel_we;
  logic [GPP_PINS-1:0] data_mask;
  logic [GPP_PINS-1:0] pin_val;
  logic [GPP_PINS-1:0] pin_drv;
  logic [GPP_PINS-1:0] wd;
  logic [GPP_DW-1:0] rd_val;
  logic req;
  logic wr;

  ////////////////////////////////////////////////////////////////////////////
  // Pin sensing and interrupt detection, one slice per pin
  genvar gi;
  generate
    for (gi = 0; gi < GPP_PINS; gi++)
    begin : g_pin
      // Digital input only counts while the pad's digital path is enabled
      assign pin_in[gi] = st_ff.sync2[gi] & st_ff.dig_en[gi];
      assign pin_prev[gi] = st_ff.sync3[gi] & st_ff.dig_en[gi];
      assign rise[gi] = pin_in[gi] & ~pin_prev[gi];
      assign fall[gi] = ~pin_in[gi] & pin_prev[gi];
      assign edge_evt[gi] = st_ff.irq_both_edge_select[gi] ? (rise[gi] | fall[gi]) :
        (st_ff.irq_polarity_select[gi] ? rise[gi] : fall[gi]);
      assign level_hit[gi] = st_ff.irq_polarity_select[gi] ? pin_in[gi] : ~pin_in[gi];
      // Level status tracks the pin and cannot be cleared while it persists
      assign raw[gi] = st_ff.irq_sense_select[gi] ? level_hit[gi] : st_ff.edge_pend[gi];
      assign mis[gi] = raw[gi] & st_ff.irq_mask[gi];
      // Peripheral owns value and direction; direction bit ignored then
      assign pin_val[gi] = st_ff.alt_function_select[gi] ? alt_out[gi] : st_ff.pin_value_reg[gi];
      assign pin_drv[gi] = st_ff.alt_function_select[gi] ? alt_oe[gi] : st_ff.direction_select[gi];
      // Open drain only ever pulls low; a high value releases the pad
      assign pad_oe[gi] = st_ff.dig_en[gi] & pin_drv[gi] & (~st_ff.open_drain_select[gi] | ~pin_val[gi]);
      assign pad_out[gi] = pin_val[gi] & ~st_ff.open_drain_select[gi];
    end
  endgenerate

  assign alt_in = pin_in;
  assign irq_out = |mis;
  assign converter_trigger = st_ff.trig;
  assign drive_2ma_select = st_ff.drive_2ma;
  assign drive_4ma_select = st_ff.drive_4ma;
  assign drive_8ma_select = st_ff.drive_8ma;
  assign slew_rate_select = st_ff.slew;
  assign pull_up_select = st_ff.pull_up;
  assign pull_down_select = st_ff.pull_down;
  assign digital_enable = st_ff.dig_en;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait cycle, then the answer
  assign req = read | write;
  assign waitrequest = req & ~st_ff.ack;
  assign wr = write & st_ff.ack & byteenable[0];
  assign wd = writedata[GPP_PINS-1:0];
  assign readdata = st_ff.rdata;
  assign data_mask = address[GPP_DATA_MSB:GPP_DATA_LSB];
  assign clr_bits = (wr && address == GPP_OFS_CLR) ? wd : '0;
  // Unprotected bits are always writable; protected ones need the key and commit
  assign afsel_we = ~DEBUG_PIN_MASK | (st_ff.commit_allow & {GPP_PINS{~st_ff.locked}});

  always_comb
  begin
    rd_val = '0;
    if (address[11:10] == GPP_DATA_PAGE)
    begin
      // Outputs read back the stored value, inputs the synchronised pin
      rd_val[GPP_PINS-1:0] = ((st_ff.direction_select & st_ff.pin_value_reg) |
        (~st_ff.direction_select & pin_in)) & data_mask;
    end
    else if (address[11:6] == GPP_ID_PAGE)
    begin
      rd_val[7:0] = GPP_ID_TABLE[address[5:2]*8 +: 8];
    end
    else
    begin
      case (address)
        GPP_OFS_DIR: rd_val[GPP_PINS-1:0] = st_ff.direction_select;
        GPP_OFS_SENSE: rd_val[GPP_PINS-1:0] = st_ff.irq_sense_select;
        GPP_OFS_BOTH: rd_val[GPP_PINS-1:0] = st_ff.irq_both_edge_select;
        GPP_OFS_POL: rd_val[GPP_PINS-1:0] = st_ff.irq_polarity_select;
        GPP_OFS_MASK: rd_val[GPP_PINS-1:0] = st_ff.irq_mask;
        GPP_OFS_RAW: rd_val[GPP_PINS-1:0] = raw;
        GPP_OFS_MIS: rd_val[GPP_PINS-1:0] = mis;
        GPP_OFS_AFSEL: rd_val[GPP_PINS-1:0] = st_ff.alt_function_select;
        GPP_OFS_DR2: rd_val[GPP_PINS-1:0] = st_ff.drive_2ma;
        GPP_OFS_DR4: rd_val[GPP_PINS-1:0] = st_ff.drive_4ma;
        GPP_OFS_DR8: rd_val[GPP_PINS-1:0] = st_ff.drive_8ma;
        GPP_OFS_ODR: rd_val[GPP_PINS-1:0] = st_ff.open_drain_select;
        GPP_OFS_PUR: rd_val[GPP_PINS-1:0] = st_ff.pull_up;
        GPP_OFS_PDR: rd_val[GPP_PINS-1:0] = st_ff.pull_down;
        GPP_OFS_SLR: rd_val[GPP_PINS-1:0] = st_ff.slew;
        GPP_OFS_DEN: rd_val[GPP_PINS-1:0] = st_ff.dig_en;
        GPP_OFS_LOCK: rd_val = st_ff.locked ? GPP_LOCK_READ : '0;
        GPP_OFS_COMMIT: rd_val[GPP_PINS-1:0] = st_ff.commit_allow;
        default: rd_val = '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.sync1 = pad_in;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.sync3 = st_ff.sync2;
    nxt_st.ack = req & ~st_ff.ack;
    if (req && !st_ff.ack)
    begin
      nxt_st.rdata = rd_val;
    end
    // A new edge in the clearing cycle wins over the clear
    nxt_st.edge_pend = (st_ff.edge_pend & ~clr_bits) | (edge_evt & ~st_ff.irq_sense_select);
    // Trigger follows the forwarded status, so unmasking a pending pin also fires it
    nxt_st.mis_prev = mis;
    nxt_st.trig = |(TRIG_SEL & mis & ~st_ff.mis_prev);
    if (wr && address[11:10] == GPP_DATA_PAGE)
    begin
      nxt_st.pin_value_reg = (st_ff.pin_value_reg & ~data_mask) | (wd & data_mask);
    end
    if (wr)
    begin
      case (address)
        GPP_OFS_DIR: nxt_st.direction_select = wd;
        GPP_OFS_SENSE: nxt_st.irq_sense_select = wd;
        GPP_OFS_BOTH: nxt_st.irq_both_edge_select = wd;
        GPP_OFS_POL: nxt_st.irq_polarity_select = wd;
        GPP_OFS_MASK: nxt_st.irq_mask = wd;
        GPP_OFS_AFSEL: nxt_st.alt_function_select = (st_ff.alt_function_select & ~afsel_we) | (wd & afsel_we);
        GPP_OFS_DR2: nxt_st.drive_2ma = wd;
        GPP_OFS_DR4: nxt_st.drive_4ma = wd;
        GPP_OFS_DR8: nxt_st.drive_8ma = wd;
        GPP_OFS_ODR: nxt_st.open_drain_select = wd;
        GPP_OFS_PUR: nxt_st.pull_up = wd;
        GPP_OFS_PDR: nxt_st.pull_down = wd;
        GPP_OFS_SLR: nxt_st.slew = wd;
        GPP_OFS_DEN: nxt_st.dig_en = wd;
        GPP_OFS_LOCK: nxt_st.locked = (writedata != GPP_UNLOCK_KEY);
        GPP_OFS_COMMIT:
        begin
          if (!st_ff.locked)
          begin
            nxt_st.commit_allow = (st_ff.commit_allow & ~DEBUG_PIN_MASK) | (wd & DEBUG_PIN_MASK);
          end
        end
        default: nxt_st.locked = st_ff.locked;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_ff <= ST_RST;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  a_irq_merge: assert property (irq_out == |(raw & st_ff.irq_mask))
    else $error("interrupt line differs from unmasked pending pins");

  a_edge_sticky: assert property (!st_ff.irq_sense_select[0] && st_ff.edge_pend[0] && !clr_bits[0]
    |=> st_ff.edge_pend[0])
    else $error("edge pending bit dropped without a clear");

  a_clear_edge: assert property (clr_bits[1] && !edge_evt[1] |=> !st_ff.edge_pend[1])
    else $error("clear write did not clear pending edge");

  a_masked_and: assert property (mis == (raw & st_ff.irq_mask) && (!st_ff.irq_mask[2] -> !mis[2]))
    else $error("masked status is not raw and mask");

  a_trig_pulse: assert property (converter_trigger |-> $past(st_ff.irq_mask[TRIGGER_PIN]) ##1 !converter_trigger)
    else $error("converter trigger not a masked one-cycle pulse");

  a_commit_guard: assert property (wr && address == GPP_OFS_AFSEL && st_ff.locked
    |=> (st_ff.alt_function_select & DEBUG_PIN_MASK) == ($past(st_ff.alt_function_select) & DEBUG_PIN_MASK))
    else $error("protected alternate bit changed while locked");

  a_level_follow: assert property (st_ff.irq_sense_select[3] && st_ff.irq_polarity_select[3] && st_ff.dig_en[3]
    && $stable(st_ff.dig_en[3]) && $past(st_ff.dig_en[3], 2) |-> raw[3] == $past(pad_in[3], 2))
    else $error("level status does not follow synchronised pin");

  a_alt_drive: assert property (st_ff.alt_function_select[5] && st_ff.dig_en[5] && !st_ff.open_drain_select[5]
    |-> pad_oe[5] == alt_oe[5] && pad_out[5] == alt_out[5])
    else $error("peripheral does not own its pin");

  a_reset_tristate: assert property ($past(srst) |-> (pad_oe & ~DEBUG_PIN_MASK) == '0
    && (st_ff.pull_down | (st_ff.pull_up & ~DEBUG_PIN_MASK)) == '0)
    else $error("pins not tristate after reset");

  a_wait_bound: assert property (req |-> ##[0:1] !waitrequest)
    else $error("bus answer later than one wait cycle");

  // Checks below tie single pins, or the whole port, to rules that the bench reaches only in bulk, or never for a commit write while locked
  a_den_gate: assert property ((pad_oe & ~st_ff.dig_en) == '0 && (alt_in & ~st_ff.dig_en) == '0)
    else $error("pin active while digital enable is off");

  a_clear_zero: assert property (wr && address == GPP_OFS_CLR && !wd[2] && st_ff.edge_pend[2]
    |=> st_ff.edge_pend[2])
    else $error("zero in clear write dropped a pending edge");

  a_edge_both: assert property (!st_ff.irq_sense_select[5] && st_ff.irq_both_edge_select[5] && fall[5]
    |=> st_ff.edge_pend[5])
    else $error("both-edge pin missed a falling edge");

  a_edge_pol: assert property (!st_ff.irq_sense_select[6] && !st_ff.irq_both_edge_select[6]
    && !st_ff.irq_polarity_select[6] && rise[6] && !st_ff.edge_pend[6] |=> !st_ff.edge_pend[6])
    else $error("falling-edge pin took a rising edge");

  a_input_dir: assert property (!st_ff.alt_function_select[6] && !st_ff.direction_select[6] |-> !pad_oe[6])
    else $error("input pin drives its pad");

  a_level_raw: assert property (st_ff.irq_sense_select[7] && st_ff.irq_polarity_select[7]
    && !st_ff.irq_mask[7] && pin_in[7] |-> raw[7])
    else $error("raw status hidden by the mask");

  a_commit_lock: assert property (wr && address == GPP_OFS_COMMIT && st_ff.locked
    |=> $stable(st_ff.commit_allow))
    else $error("commit bits changed while locked");

  c_edge_irq: cover property (!st_ff.irq_sense_select[0] && rise[0] ##1 irq_out);
  c_clear_pend: cover property (st_ff.edge_pend[0] ##1 clr_bits[0] ##1 !st_ff.edge_pend[0]);
  c_level_irq: cover property (st_ff.irq_sense_select[1] && mis[1]);
  c_unlock: cover property (wr && address == GPP_OFS_LOCK && writedata == GPP_UNLOCK_KEY);
  c_trigger: cover property (converter_trigger);

endmodule // gpp_port

// *** verification/gpp_pin_model.sv ***
// Far-side model: pin wires and the peripheral behind the alternate function
module gpp_pin_model
  import gpp_pkg::*;
(
  input wire logic [GPP_PINS-1:0] ext_level,
  input wire logic [GPP_PINS-1:0] pad_out,
  input wire logic [GPP_PINS-1:0] pad_oe,
  input wire logic [GPP_PINS-1:0] per_val,
  input wire logic per_en,
  output logic [GPP_PINS-1:0] pad_in,
  output logic [GPP_PINS-1:0] alt_out,
  output logic [GPP_PINS-1:0] alt_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////////
  // Driven pins show the pad value; others show the external level, passed straight through
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
  // Idle peripheral drives nothing, so a stale alternate value cannot pass
  assign alt_out = per_val;
  assign alt_oe = per_en ? (per_val ^ 8'h5a) : 8'h00;
endmodule // gpp_pin_model

// *** verification/gpio_port_irq_mode_pad_control_test.sv ***
// Self-checking bench for the eight-pin port: interrupts, mode, commit, pads
module gpio_port_irq_mode_pad_control_test
  import gpp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [11:0] address = 12'h000;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [3:0] byteenable = 4'hf;
  logic [31:0] writedata = 32'h0;
  logic [7:0] ext_level = 8'h00;
  logic [7:0] per_val = 8'h00;
  logic per_en = 1'b0;
  logic [31:0] readdata, seed, q;
  logic waitrequest, irq_out, converter_trigger, wr_mid;
  logic [7:0] pad_in, pad_out, pad_oe, alt_out, alt_oe, alt_in, drive_2ma_select, drive_4ma_select;
  logic [7:0] drive_8ma_select, slew_rate_select, pull_up_select, pull_down_select, digital_enable;
  logic [7:0] d, a, v, m, e, p, eoe, eout, epin, p0, p1, mk, er, c;
  logic [11:0] cfg[$] = '{GPP_OFS_DR2, GPP_OFS_DR4, GPP_OFS_DR8, GPP_OFS_ODR, GPP_OFS_PUR,
    GPP_OFS_PDR, GPP_OFS_SLR, GPP_OFS_DEN};
  bit s, b, pl;
  int error_cnt, num_checks, trig_cnt;

  gpp_port #(.DEBUG_PIN_MASK(8'h80), .HAS_TRIGGER(1'b1), .TRIGGER_PIN(4)) DUT (.clk, .srst,
    .address, .read, .write, .byteenable, .writedata, .readdata, .waitrequest, .pad_in, .pad_out,
    .pad_oe, .alt_out, .alt_oe, .alt_in, .drive_2ma_select, .drive_4ma_select, .drive_8ma_select,
    .slew_rate_select, .pull_up_select, .pull_down_select, .digital_enable, .irq_out,
    .converter_trigger);
  gpp_pin_model far (.ext_level, .pad_out, .pad_oe, .per_val, .per_en, .pad_in, .alt_out, .alt_oe);

  ////////////////////////////////////////////////////////////////////////////
  always #5 clk = ~clk;
  // Mid-cycle copy equals the value seen at the next rising edge
  always @(negedge clk) wr_mid = waitrequest;
  always @(posedge clk) if (converter_trigger === 1'b1) trig_cnt++;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [7:0] pad_port(int i);
    case (i)
      0: return drive_2ma_select;
      1: return drive_4ma_select;
      2: return drive_8ma_select;
      4: return pull_up_select;
      5: return pull_down_select;
      6: return slew_rate_select;
      default: return digital_enable;
    endcase
  endfunction

  task automatic chk_rd(input logic [11:0] n, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x)
    begin
      error_cnt++;
      $display("mismatch reg_%h expected %h seen %h", n, x, g);
    end
  endtask

  task automatic chk_pin(input string n, input logic [7:0] x, input logic [7:0] g);
    num_checks++;
    if (g !== x)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic bus(input logic rd, input logic [11:0] ad, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    address <= ad;
    read <= rd;
    write <= ~rd;
    writedata <= wd;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wr_mid !== 1'b0 && n < 40);
    if (n >= 40) error_cnt++;
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] ad, input logic [31:0] wd);
    bus(1'b0, ad, wd);
  endtask

  task automatic rc(input logic [11:0] ad, input logic [31:0] x);
    bus(1'b1, ad, 32'h0);
    chk_rd(ad, x, q);
  endtask

  task automatic end_of_test;
    if (error_cnt == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    #500000;
    error_cnt++;
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 32'he104;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    // Port clock counts as enabled from here on
    chk_pin("pad_oe", 8'h00, pad_oe & 8'h7f);
    rc(GPP_OFS_AFSEL, 32'h80);
    rc(GPP_OFS_DEN, 32'h80);
    rc(GPP_OFS_PUR, 32'h80);
    rc(GPP_OFS_PDR, 32'h0);
    rc(GPP_OFS_DR2, GPP_DR2_RST);
    rc(GPP_OFS_LOCK, GPP_LOCK_READ);
    rc(GPP_OFS_COMMIT, 32'h7f);
    wr(12'hfe0, 32'h0);
    for (int k = 4; k < 16; k++) rc({GPP_ID_PAGE, k[3:0], 2'b00}, GPP_ID_TABLE[k*8 +: 8]);
    wr(12'h600, 32'hff);
    rc(12'h600, 32'h0);
    byteenable <= 4'h0;
    wr(GPP_OFS_DR4, 32'hff);
    byteenable <= 4'hf;
    rc(GPP_OFS_DR4, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      v = xs();
      wr(cfg[i], v);
      rc(cfg[i], v);
      if (i != 3) chk_pin("pad_ctl", v, pad_port(i));
    end
    wr(GPP_OFS_ODR, 32'h0);
    wr(GPP_OFS_DEN, 32'hff);
    // Locked: the protected bit refuses, others follow
    wr(GPP_OFS_AFSEL, 32'h0);
    rc(GPP_OFS_AFSEL, 32'h80);
    wr(GPP_OFS_LOCK, GPP_UNLOCK_KEY);
    wr(GPP_OFS_COMMIT, 32'hff);
    rc(GPP_OFS_COMMIT, 32'hff);
    wr(GPP_OFS_AFSEL, 32'h0);
    rc(GPP_OFS_AFSEL, 32'h0);
    per_en <= 1'b1;
    for (int k = 0; k < 6; k++)
    begin
      {d, a, v, m} = xs();
      e = xs();
      p = xs();
      ext_level <= e;
      per_val <= p;
      wr(GPP_OFS_DIR, d);
      wr(GPP_OFS_AFSEL, a);
      wr(12'h3fc, v);
      c = xs();
      wr({2'b00, c, 2'b00}, ~v);
      v = (v & ~c) | (~v & c);
      repeat (4) @(posedge clk);
      eoe = (a & (p ^ 8'h5a)) | (~a & d);
      eout = (a & p) | (~a & v);
      epin = (eoe & eout) | (~eoe & e);
      chk_pin("pad_oe", eoe, pad_oe);
      chk_pin("pad_out", eout, pad_out);
      chk_pin("alt_in", epin, alt_in);
      rc({2'b00, m, 2'b00}, m & ((d & v) | (~d & epin)));
    end
    wr(GPP_OFS_DEN, 32'h0);
    // The write lands at the edge the task returns on; look one edge later
    @(posedge clk);
    chk_pin("pad_oe", 8'h00, pad_oe);
    rc(12'h3fc, d & v);
    wr(GPP_OFS_DEN, 32'hff);
    wr(GPP_OFS_AFSEL, 32'h0);
    wr(GPP_OFS_DIR, 32'h0);
    wr(GPP_OFS_LOCK, 32'h0);
    rc(GPP_OFS_LOCK, GPP_LOCK_READ);
    per_en <= 1'b0;
    for (int k = 0; k < 10; k++)
    begin
      s = (k % 5) >= 3;
      b = (k % 5) == 2;
      pl = (k % 5) == 1 || (k % 5) == 4;
      wr(GPP_OFS_MASK, 32'h0);
      wr(GPP_OFS_SENSE, {8{s}});
      wr(GPP_OFS_BOTH, {8{b}});
      wr(GPP_OFS_POL, {8{pl}});
      p0 = xs();
      ext_level <= p0;
      repeat (6) @(posedge clk);
      wr(GPP_OFS_CLR, 32'hff);
      p1 = xs();
      ext_level <= p1;
      repeat (6) @(posedge clk);
      mk = xs();
      trig_cnt = 0;
      wr(GPP_OFS_MASK, mk);
      repeat (4) @(posedge clk);
      er = s ? (pl ? p1 : ~p1) : (b ? p0 ^ p1 : (pl ? ~p0 & p1 : p0 & ~p1));
      rc(GPP_OFS_RAW, er);
      rc(GPP_OFS_MIS, er & mk);
      chk_pin("irq_out", {7'h0, |(er & mk)}, {7'h0, irq_out});
      chk_pin("trig_cnt", {7'h0, er[4] & mk[4]}, trig_cnt[7:0]);
      ext_level <= p0;
      repeat (6) @(posedge clk);
      // Going back to p0 gives the opposite edge on every changed pin; pending bits stay
      er = s ? (pl ? p0 : ~p0) : p0 ^ p1;
      rc(GPP_OFS_RAW, er);
      chk_pin("irq_out", {7'h0, |(er & mk)}, {7'h0, irq_out});
      c = xs();
      wr(GPP_OFS_CLR, c);
      er = s ? er : er & ~c;
      rc(GPP_OFS_RAW, er);
    end
    end_of_test();
  end
endmodule // gpio_port_irq_mode_pad_control_test
